// ---- tb/avm_axi_pair.sv ----
`timescale 1ns/1ps
// ====================================================================
// Master and slave pair on the watched connection.
// ====================================================================
module avm_axi_pair (
    input wire logic sys_clk,
    output logic [3:0] awId,
    output logic [3:0] arId,
    output logic [3:0] bId,
    output logic [3:0] rId,
    output logic [3:0] wStrb,
    output logic [31:0] awAddr,
    output logic [31:0] arAddr,
    output logic [31:0] wData,
    output logic [31:0] rData,
    output logic [7:0] awLen,
    output logic [7:0] arLen,
    output logic [2:0] awSize,
    output logic [2:0] arSize,
    output logic [1:0] awBurst,
    output logic [1:0] arBurst,
    output logic [1:0] bResp,
    output logic [1:0] rResp,
    output logic wLast,
    output logic rLast,
    output logic awUser,
    output logic arUser,
    output logic wUser,
    output logic rUser,
    output logic bUser,
    output logic awValid,
    output logic awReady,
    output logic wValid,
    output logic wReady,
    output logic bValid,
    output logic bReady,
    output logic arValid,
    output logic arReady,
    output logic rValid,
    output logic rReady
);
    logic [4:0] vld = 5'h00;
    logic [4:0] rdy = 5'h00;
    // Channel order is AW, W, B, AR, R, as in the flag map.
    assign {rValid, arValid, bValid, wValid, awValid} = vld;
    assign {rReady, arReady, bReady, wReady, awReady} = rdy;
    // Legal single-beat payload; only the commanded faults break it.
    logic rsvd = 1'b0;
    logic big = 1'b0;
    logic bump = 1'b0;
    logic [31:0] addrW = 32'h1000;
    logic [31:0] addrR = 32'h2000;
    logic [31:0] dataW = 32'h5a5a;
    logic [31:0] dataR = 32'ha5a5;
    assign {awId, arId, bId, rId, wStrb} = 20'h0000f;
    assign {awLen, arLen, arSize, bResp, rResp} = {16'h0000, 3'h2, 4'h0};
    assign awSize = big ? 3'h3 : 3'h2;
    assign awBurst = rsvd ? 2'h3 : 2'h1;
    assign arBurst = rsvd ? 2'h3 : 2'h1;
    assign {wLast, rLast, awUser, arUser, wUser, rUser, bUser} = 7'h60;
    assign {awAddr, arAddr, wData, rData} = {addrW, addrR, dataW, dataR};
    // Idle payload keeps moving, so a monitor that ignores valid would be caught;
    // each word has this one writer, and the stall fault asks it for one more step.
    always @(posedge sys_clk) begin
        if (!vld[0] || bump) addrW <= ~addrW;
        if (!vld[1]) dataW <= ~dataW;
        if (!vld[3]) addrR <= ~addrR;
        if (!vld[4]) dataR <= ~dataR;
    end
    // One handshake, with the ready side slow by the given count.
    task automatic hs(input int ch, input int stall);
        vld[ch] <= 1'b1;
        repeat (stall) @(posedge sys_clk);
        rdy[ch] <= 1'b1;
        @(posedge sys_clk);
        vld[ch] <= 1'b0;
        rdy[ch] <= 1'b0;
    endtask
    // Commanded fault: the address moves while the slave stalls.
    task automatic shake();
        vld[0] <= 1'b1;
        bump <= 1'b1;
        @(posedge sys_clk);
        bump <= 1'b0;
        @(posedge sys_clk);
        hs(0, 0);
    endtask
    // Commanded fault: valid is withdrawn while the slave stalls.
    task automatic quit(input int ch);
        vld[ch] <= 1'b1;
        @(posedge sys_clk);
        vld[ch] <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Commanded fault: a write address whose size code exceeds the data bus.
    task automatic oversize();
        big <= 1'b1;
        hs(0, 0);
        big <= 1'b0;
    endtask
    // Commanded fault: reserved burst code on both address channels at once.
    task automatic bursts();
        rsvd <= 1'b1;
        fork
            hs(0, 0);
            hs(3, 0);
        join
        rsvd <= 1'b0;
    endtask
endmodule // avm_axi_pair

// ---- tb/avm_axi_violation_monitor_bench.sv ----
`timescale 1ns/1ps
module avm_axi_violation_monitor_bench;
    import avm_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b1;
    logic coreReset_n = 1'b1;
    logic [3:0] awId, arId, bId, rId, wStrb;
    logic [31:0] awAddr, arAddr, wData, rData;
    logic [7:0] awLen, arLen;
    logic [2:0] awSize, arSize;
    logic [1:0] awBurst, arBurst, bResp, rResp;
    logic wLast, rLast, awUser, arUser, wUser, rUser, bUser;
    logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
    logic [AVM_FLAG_W-1:0] violation_flag_vector;
    logic any_violation_out;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    avm_axi_violation_monitor u_dut (.*);
    avm_axi_pair u_pair (.*);
    initial forever #2.5 sys_clk = ~sys_clk;
    // The whole run needs well under a thousand cycles.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end
    function automatic logic [AVM_FLAG_W-1:0] fl(input int b);
        logic [AVM_FLAG_W-1:0] one;
        one = '0;
        one[b] = 1'b1;
        return one;
    endfunction
    // Looks a step after the edge, once the flag registers have landed.
    task automatic chk(input string what, input logic [AVM_FLAG_W-1:0] exp);
        #1;
        tests_run++;
        if (violation_flag_vector !== exp || any_violation_out !== (|exp)) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, violation_flag_vector);
        end
        @(posedge sys_clk);
    endtask
    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
    endtask
    // Two writes and two reads outstanding, slow and prompt answers.
    task automatic t_clean();
        u_pair.hs(0, 1);
        u_pair.hs(3, 0);
        u_pair.hs(0, 0);
        u_pair.hs(3, 2);
        u_pair.hs(1, 3);
        u_pair.hs(4, 0);
        u_pair.hs(2, 0);
        u_pair.hs(4, 1);
        u_pair.hs(1, 0);
        u_pair.hs(2, 2);
        chk("clean traffic", '0);
        $display("test clean done");
    endtask
    task automatic t_stall();
        u_pair.shake();
        chk("stalled change", fl(AVM_BIT_STABLE));
        u_pair.hs(1, 1);
        u_pair.hs(2, 0);
        chk("flag kept", fl(AVM_BIT_STABLE));
        coreReset_n <= 1'b0;
        @(posedge sys_clk);
        coreReset_n <= 1'b1;
        chk("core reset", '0);
        $display("test stall and core reset done");
    endtask
    task automatic t_bursts();
        u_pair.bursts();
        chk("joint bursts", fl(AVM_BIT_AWBURST) | fl(AVM_BIT_ARBURST));
        u_pair.shake();
        chk("later flag", fl(AVM_BIT_AWBURST) | fl(AVM_BIT_ARBURST) | fl(AVM_BIT_STABLE));
        $display("test bursts done");
    endtask
    task automatic t_reset();
        do_reset();
        chk("interface reset", '0);
        u_pair.hs(2, 0);
        chk("orphan response", fl(AVM_BIT_BORPHAN));
        $display("test reset done");
    endtask
    // A dropped write beat, then an oversized write and an orphan read end together.
    task automatic t_faults();
        logic [AVM_FLAG_W-1:0] base;
        base = fl(AVM_BIT_BORPHAN) | fl(AVM_BIT_DROP + AVM_CH_W);
        u_pair.quit(AVM_CH_W);
        chk("dropped beat", base);
        fork
            u_pair.oversize();
            u_pair.hs(AVM_CH_R, 0);
        join
        chk("size and orphan", base | fl(AVM_BIT_AWSIZE) | fl(AVM_BIT_RORPHAN));
        $display("test faults done");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_clean();
        t_stall();
        t_bursts();
        t_reset();
        t_faults();
        wrap_up();
    end
endmodule // avm_axi_violation_monitor_bench
bind avm_axi_violation_monitor avm_mon_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.sys_clk(sys_clk),
    .reset_n(reset_n), .coreReset_n(coreReset_n), .awValid(awValid), .awReady(awReady), .arValid(arValid),
    .any_violation_out(any_violation_out), .awAddr(awAddr), .awBurst(awBurst), .arBurst(arBurst),
    .violation_flag_vector(violation_flag_vector));

// ---- tb/avm_mon_asserts.sv ----
`timescale 1ns/1ps
// ====================================================================
// Port checker for the violation monitor.
// ====================================================================
module avm_mon_asserts #(
    parameter int ADDR_WIDTH = 32
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic coreReset_n,
    input wire logic awValid,
    input wire logic awReady,
    input wire logic arValid,
    input wire logic any_violation_out,
    input wire logic [ADDR_WIDTH-1:0] awAddr,
    input wire logic [1:0] awBurst,
    input wire logic [1:0] arBurst,
    input wire logic [avm_pkg::AVM_FLAG_W-1:0] violation_flag_vector
);
    import avm_pkg::*;
    logic [AVM_FLAG_W-1:0] fv;
    assign fv = violation_flag_vector;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // A flag rises on its detecting edge, so it is first seen one sample later.
    chk_any_mirrors_or: assert property (
        any_violation_out == |fv) else $error("any output differs from flag OR");
    chk_flags_stay_set: assert property (
        $past(coreReset_n) |-> ($past(fv) & ~fv) == '0) else $error("a set flag was lost");
    chk_core_clears_all: assert property (
        !coreReset_n |=> fv == '0 && !any_violation_out) else $error("core reset left flags set");
    chk_unused_bits_low: assert property (
        fv[AVM_FLAG_W-1:20] == '0) else $error("unmapped flag bit set");
    chk_stall_change_flag: assert property (
        awValid && !awReady ##1 awValid && coreReset_n && awAddr != $past(awAddr) |=> fv[AVM_BIT_STABLE])
        else $error("stalled address change not flagged");
    chk_burst_code_flag: assert property (
        awValid && awBurst == AVM_BURST_RSVD && coreReset_n |=> fv[AVM_BIT_AWBURST])
        else $error("reserved write burst not flagged");
    chk_both_bursts_flag: assert property (
        awValid && arValid && awBurst == AVM_BURST_RSVD && arBurst == AVM_BURST_RSVD && coreReset_n
        |=> fv[AVM_BIT_AWBURST] && fv[AVM_BIT_ARBURST]) else $error("joint burst flags missing");
    chk_reset_empties: assert property (
        disable iff (1'b0) !reset_n |-> fv == '0 && !any_violation_out) else $error("flags set in reset");
endmodule // avm_mon_asserts

// ---- verilog/avm_axi_violation_monitor.sv ----
`timescale 1ns/1ps
module avm_axi_violation_monitor #(
    parameter avm_pkg::avm_proto_e PROTOCOL = avm_pkg::AVM_PROTO_AXI4,
    parameter int DATA_WIDTH = 32,
    parameter int ADDR_WIDTH = 32,
    parameter int ID_WIDTH = 4,
    parameter int AWUSER_WIDTH = 1,
    parameter int ARUSER_WIDTH = 1,
    parameter int WUSER_WIDTH = 1,
    parameter int RUSER_WIDTH = 1,
    parameter int BUSER_WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic coreReset_n,
    input wire logic [ID_WIDTH-1:0] awId,
    input wire logic [ADDR_WIDTH-1:0] awAddr,
    input wire logic [7:0] awLen,
    input wire logic [2:0] awSize,
    input wire logic [1:0] awBurst,
    input wire logic [AWUSER_WIDTH-1:0] awUser,
    input wire logic awValid,
    input wire logic awReady,
    input wire logic [DATA_WIDTH-1:0] wData,
    input wire logic [DATA_WIDTH/8-1:0] wStrb,
    input wire logic wLast,
    input wire logic [WUSER_WIDTH-1:0] wUser,
    input wire logic wValid,
    input wire logic wReady,
    input wire logic [ID_WIDTH-1:0] bId,
    input wire logic [1:0] bResp,
    input wire logic [BUSER_WIDTH-1:0] bUser,
    input wire logic bValid,
    input wire logic bReady,
    input wire logic [ID_WIDTH-1:0] arId,
    input wire logic [ADDR_WIDTH-1:0] arAddr,
    input wire logic [7:0] arLen,
    input wire logic [2:0] arSize,
    input wire logic [1:0] arBurst,
    input wire logic [ARUSER_WIDTH-1:0] arUser,
    input wire logic arValid,
    input wire logic arReady,
    input wire logic [ID_WIDTH-1:0] rId,
    input wire logic [DATA_WIDTH-1:0] rData,
    input wire logic [1:0] rResp,
    input wire logic rLast,
    input wire logic [RUSER_WIDTH-1:0] rUser,
    input wire logic rValid,
    input wire logic rReady,
    output logic [avm_pkg::AVM_FLAG_W-1:0] violation_flag_vector,
    output logic any_violation_out
);
    import avm_pkg::*;

    // ==================================================================
    // Configuration limits
    // ==================================================================
    // Widths outside the legal sets hold every detect bit low, though the registers and counters still elaborate, so a bad
    // configuration shows as flags stuck at zero rather than as wrong checks.
    localparam bit FULL_OK = (DATA_WIDTH == 32) || (DATA_WIDTH == 64) || (DATA_WIDTH == 128)
        || (DATA_WIDTH == 256) || (DATA_WIDTH == 512) || (DATA_WIDTH == 1024);
    localparam bit LITE_OK = (DATA_WIDTH == 32) || (DATA_WIDTH == 64);
    localparam bit IS_LITE = (PROTOCOL == AVM_PROTO_LITE);
    localparam bit WIDTH_OK = (IS_LITE ? LITE_OK : FULL_OK)
        && (ADDR_WIDTH <= AVM_ADDR_MAX)
        && (ID_WIDTH <= AVM_ID_MAX)
        && (AWUSER_WIDTH <= AVM_USER_MAX) && (ARUSER_WIDTH <= AVM_USER_MAX)
        && (WUSER_WIDTH <= AVM_USER_MAX) && (RUSER_WIDTH <= AVM_USER_MAX)
        && (BUSER_WIDTH <= AVM_USER_MAX);
    // Largest legal size code: no beat may be wider than the data bus.
    localparam logic [2:0] MAX_SIZE = 3'($clog2(DATA_WIDTH / 8));

    // ==================================================================
    // Channel payloads, packed to one common width
    // ==================================================================
    // Thirteen bits carry the length, size and burst fields of an address beat;
    // three carry the response code and last marker of a read beat.
    localparam int AW_W = ID_WIDTH + ADDR_WIDTH + 13 + AWUSER_WIDTH;
    localparam int AR_W = ID_WIDTH + ADDR_WIDTH + 13 + ARUSER_WIDTH;
    localparam int W_W = DATA_WIDTH + DATA_WIDTH / 8 + 1 + WUSER_WIDTH;
    localparam int R_W = ID_WIDTH + DATA_WIDTH + 3 + RUSER_WIDTH;
    localparam int B_W = ID_WIDTH + 2 + BUSER_WIDTH;
    localparam int PAY_W = (AW_W > AR_W ? AW_W : AR_W) > (W_W > R_W ? W_W : R_W)
        ? (AW_W > AR_W ? AW_W : AR_W) : (W_W > R_W ? W_W : R_W);

    // The monitored signals are only ever read here; the module has no output
    // towards either party of the connection.
    wire [PAY_W-1:0] payload [AVM_CHANNELS];
    wire [AVM_CHANNELS-1:0] chValid;
    wire [AVM_CHANNELS-1:0] chReady;
    assign payload[AVM_CH_AW] = PAY_W'({awId, awAddr, awLen, awSize, awBurst, awUser});
    assign payload[AVM_CH_W] = PAY_W'({wData, wStrb, wLast, wUser});
    assign payload[AVM_CH_B] = PAY_W'({bId, bResp, bUser});
    assign payload[AVM_CH_AR] = PAY_W'({arId, arAddr, arLen, arSize, arBurst, arUser});
    assign payload[AVM_CH_R] = PAY_W'({rId, rData, rResp, rLast, rUser});
    // Valid and ready are gathered in the channel order of the flag map.
    assign chValid = {rValid, arValid, bValid, wValid, awValid};
    assign chReady = {rReady, arReady, bReady, wReady, awReady};

    // One detect bit per flag, high in the cycle whose inputs break a rule.
    logic [AVM_FLAG_W-1:0] detect;
    logic [AVM_FLAG_W-1:0] next_flags;
    logic [AVM_CNT_W-1:0] wrOutstanding;
    logic [AVM_CNT_W-1:0] rdOutstanding;

    // ==================================================================
    // Handshake stability checks, one per channel
    // ==================================================================
    // The payload is compared as one word, so a change of data, strobe or user
    // sideband is caught as surely as a change of address.
    genvar ch;
    generate
        for (ch = 0; ch < AVM_CHANNELS; ch++) begin : gStable
            logic stalled;
            logic [PAY_W-1:0] heldPayload;
            // A beat offered without ready must hold its payload and its valid.
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    stalled <= 1'b0;
                    heldPayload <= '0;
                end else begin
                    stalled <= chValid[ch] && !chReady[ch];
                    heldPayload <= payload[ch];
                end
            end
            assign detect[AVM_BIT_STABLE + ch] = WIDTH_OK && stalled && chValid[ch]
                && (payload[ch] != heldPayload);
            assign detect[AVM_BIT_DROP + ch] = WIDTH_OK && stalled && !chValid[ch];
        end
    endgenerate

    // ==================================================================
    // Outstanding transaction tracking
    // ==================================================================
    // Handshake strobes and counter limits. A Lite read has a single beat, so
    // every accepted read beat closes its transaction there.
    wire awFire = awValid && awReady;
    wire bFire = bValid && bReady;
    wire arFire = arValid && arReady;
    wire rEndFire = rValid && rReady && (rLast || IS_LITE);
    wire wrEmpty = (wrOutstanding == AVM_CNT_ZERO);
    wire rdEmpty = (rdOutstanding == AVM_CNT_ZERO);
    wire wrFull = (wrOutstanding == AVM_CNT_FULL);
    wire rdFull = (rdOutstanding == AVM_CNT_FULL);

    // Counters saturate; an overflow is flagged rather than wrapped so the
    // orphan checks never see a false empty.
    // The core reset leaves both counts alone, so transactions in flight keep
    // their pairing across it; only the interface reset empties them.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrOutstanding <= AVM_CNT_ZERO;
            rdOutstanding <= AVM_CNT_ZERO;
        end else begin
            if (awFire && !(bFire && !wrEmpty) && !wrFull) begin
                wrOutstanding <= wrOutstanding + AVM_CNT_ONE;
            end else if (bFire && !awFire && !wrEmpty) begin
                wrOutstanding <= wrOutstanding - AVM_CNT_ONE;
            end
            if (arFire && !(rEndFire && !rdEmpty) && !rdFull) begin
                rdOutstanding <= rdOutstanding + AVM_CNT_ONE;
            end else if (rEndFire && !arFire && !rdEmpty) begin
                rdOutstanding <= rdOutstanding - AVM_CNT_ONE;
            end
        end
    end

    // ==================================================================
    // Field and ordering checks
    // ==================================================================
    // A response in the same cycle as its address is legal for neither
    // channel, so the same-cycle address does not excuse an empty count.
    // Size and burst codes are judged while valid is high, whether or not ready is.
    assign detect[AVM_BIT_AWSIZE] = WIDTH_OK && awValid && (awSize > MAX_SIZE);
    assign detect[AVM_BIT_ARSIZE] = WIDTH_OK && arValid && (arSize > MAX_SIZE);
    assign detect[AVM_BIT_AWBURST] = WIDTH_OK && !IS_LITE && awValid && (awBurst == AVM_BURST_RSVD);
    assign detect[AVM_BIT_ARBURST] = WIDTH_OK && !IS_LITE && arValid && (arBurst == AVM_BURST_RSVD);
    assign detect[AVM_BIT_BORPHAN] = WIDTH_OK && bFire && wrEmpty;
    assign detect[AVM_BIT_RORPHAN] = WIDTH_OK && rEndFire && rdEmpty;
    assign detect[AVM_BIT_WOVFL] = WIDTH_OK && awFire && wrFull && !bFire;
    assign detect[AVM_BIT_ROVFL] = WIDTH_OK && arFire && rdFull && !rEndFire;
    assign detect[AVM_BIT_LITELEN] = WIDTH_OK && IS_LITE
        && ((awValid && (awLen != AVM_LEN_SINGLE)) || (arValid && (arLen != AVM_LEN_SINGLE)));
    assign detect[AVM_BIT_LITELAST] = WIDTH_OK && IS_LITE
        && ((wValid && !wLast) || (rValid && !rLast));
    assign detect[AVM_FLAG_W-1:AVM_BIT_LITELAST+1] = '0;

    // ==================================================================
    // Sticky flag vector and summary output
    // ==================================================================
    // Every detect bit ORs into its own flag, so any mix of bits may set in a
    // cycle; only a reset takes a flag down again.
    // Limitation: a flag names the broken rule, not the beat or identifier at fault.
    assign next_flags = coreReset_n ? (violation_flag_vector | detect)
        : AVM_FLAGS_CLEAR;

    // The summary is computed from the next vector so it moves on the same edge.
    // Taking it from the registered vector instead would lag the flags by a cycle.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            violation_flag_vector <= AVM_FLAGS_CLEAR;
            any_violation_out <= 1'b0;
        end else begin
            violation_flag_vector <= next_flags;
            any_violation_out <= |next_flags;
        end
    end

endmodule // avm_axi_violation_monitor

// ---- verilog/avm_pkg.sv ----
package avm_pkg;

    // ==================================================================
    // Protocol selection
    // ==================================================================
    typedef enum {
        AVM_PROTO_AXI4,
        AVM_PROTO_AXI3,
        AVM_PROTO_LITE
    } avm_proto_e;

    // ==================================================================
    // Sizes
    // ==================================================================
    localparam int AVM_FLAG_W = 160;
    localparam int AVM_ADDR_MAX = 64;
    localparam int AVM_USER_MAX = 1024;
    localparam int AVM_ID_MAX = 32;
    localparam int AVM_CNT_W = 8;
    localparam logic [AVM_CNT_W-1:0] AVM_CNT_ZERO = 8'h00;
    localparam logic [AVM_CNT_W-1:0] AVM_CNT_ONE = 8'h01;
    localparam logic [AVM_CNT_W-1:0] AVM_CNT_FULL = 8'hff;
    localparam logic [1:0] AVM_BURST_RSVD = 2'h3;
    localparam logic [7:0] AVM_LEN_SINGLE = 8'h00;
    localparam logic [AVM_FLAG_W-1:0] AVM_FLAGS_CLEAR = '0;

    // ==================================================================
    // Flag positions in the violation vector
    // ==================================================================
    localparam int AVM_CHANNELS = 5;
    localparam int AVM_CH_AW = 0;
    localparam int AVM_CH_W = 1;
    localparam int AVM_CH_B = 2;
    localparam int AVM_CH_AR = 3;
    localparam int AVM_CH_R = 4;
    localparam int AVM_BIT_STABLE = 0;
    localparam int AVM_BIT_DROP = 5;
    localparam int AVM_BIT_AWSIZE = 10;
    localparam int AVM_BIT_ARSIZE = 11;
    localparam int AVM_BIT_AWBURST = 12;
    localparam int AVM_BIT_ARBURST = 13;
    localparam int AVM_BIT_BORPHAN = 14;
    localparam int AVM_BIT_RORPHAN = 15;
    localparam int AVM_BIT_WOVFL = 16;
    localparam int AVM_BIT_ROVFL = 17;
    localparam int AVM_BIT_LITELEN = 18;
    localparam int AVM_BIT_LITELAST = 19;

endpackage
